// >>> hdl/i2c_port_expander_slave.sv
/*
   Serial slave in front of a 16-pin, two-port I/O expander.
   Assumes: serial_clk is the bus clock pin used as a clock; sda and
   interrupt are open drain, resolved outside; address straps are static.
*/
// Function
// - Shift every serial bit on the master's serial clock edges.
// - Data line only pulled low or released, never driven high.
// - Address bits 3..1 must equal the three strap pins.
// - Address top nibble must be the fixed prefix 0100.
// - Input pins have both output transistors off.
// - Output pins drive both levels push-pull.
// - Interrupt asserts when an input pin differs from its read reference.
// - Interrupt clears when level returns or the port is read.
// - Reading one port never clears the other port's change.
// - Output-to-input switch may raise a spurious interrupt.
// - Data stable during clock high; changes then are START or STOP.
// - START is data falling with clock high; ignore everything before.
// - STOP is data rising with clock high; master ends with STOP.
// - Eighth address bit selects read when 1, write when 0.
// - Acknowledge a matching address; stay silent otherwise.
// - Receiver pulls data low for the whole ninth clock high.
// - In write, acknowledge every data byte.
// - Read sends eight bits, releases, continues only on master ack.
// - No master ack ends sending; wait for STOP.
// - First written byte is the command selecting register 0 to 7.
// - After each byte, pointer flips to the other register of the pair.
// - Polarity bit 1 inverts the input register bit.
// - Direction bit 0 makes an output, 1 an input.
`timescale 1ns/1ps
module i2c_port_expander_slave
   import pexp_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       serial_clk,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic       addr_strap_bit0,
   input  wire logic       addr_strap_bit1,
   input  wire logic       addr_strap_bit2,
   input  wire logic [7:0] port_low_pins_i,
   output logic      [7:0] port_low_pins_o,
   output logic      [7:0] port_low_pins_oe,
   input  wire logic [7:0] port_high_pins_i,
   output logic      [7:0] port_high_pins_o,
   output logic      [7:0] port_high_pins_oe,
   output logic            int_n_o,
   output logic            int_n_oe
);

   // ==========================================================
   // Reset release
   logic [1:0]        rst_pipe;
   logic              rst_n;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe[1];

   // ==========================================================
   // Declarations
   logic              start_tgl;
   logic              stop_tgl;
   logic              start_seen;
   logic              stop_seen;
   logic              start_pend;
   logic              stop_pend;
   link_state_t       state;
   logic [3:0]        bit_cnt;
   logic [6:0]        shift;
   logic [7:0]        rx_byte;
   logic              ack_en;
   logic              rw;
   logic [2:0]        ptr;
   reg_write_t        wr_word;
   logic              wr_tgl;
   logic [2:0]        rd_ptr;
   logic              rd_tgl;
   logic [7:0]        tx;
   logic              addr_hit;
   logic              master_ack;

   logic [20:0]       sync_in;
   logic [20:0]       sync_out;
   logic [7:0]        low_sync;
   logic [7:0]        high_sync;
   logic [2:0]        strap;
   logic              wr_tgl_sync;
   logic              rd_tgl_sync;
   logic              wr_seen;
   logic              rd_seen;
   logic              wr_evt;
   logic              rd_evt;
   logic [7:0]        rd_data;
   logic [7:0]        bank_pins  [2];
   logic [7:0]        bank_in    [2];
   logic [7:0]        bank_out   [2];
   logic [7:0]        bank_pol   [2];
   logic [7:0]        bank_cfg   [2];
   logic [7:0]        bank_pout  [2];
   logic [7:0]        bank_poe   [2];
   logic [1:0]        bank_change;

   // ==========================================================
   // START and STOP detection
   // Clocked by the data line itself: the bus clock stands still around
   // these conditions, so only the data edge can catch them.
   // START data falls with clock high
   always_ff @(negedge sda_i or negedge rst_n) begin
      if (!rst_n) begin
         start_tgl <= 1'b0;
      end else if (serial_clk) begin
         start_tgl <= ~start_tgl;
      end
   end

   // STOP data rises with clock high
   always_ff @(posedge sda_i or negedge rst_n) begin
      if (!rst_n) begin
         stop_tgl <= 1'b0;
      end else if (serial_clk) begin
         stop_tgl <= ~stop_tgl;
      end
   end

   // Toggles settle a full hold time before the next clock edge
   assign start_pend = start_tgl != start_seen;
   assign stop_pend  = stop_tgl != stop_seen;
   assign rx_byte    = {shift, sda_i};
   assign addr_hit   = (shift[6:3] == ADDR_PREFIX) && (shift[2:0] == strap);
   assign master_ack = !sda_i;

   // ==========================================================
   // Link engine, rising clock edge
   // data sampled only on rising edges
   always_ff @(posedge serial_clk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= LINK_IDLE;
         bit_cnt    <= 4'h0;
         shift      <= 7'h00;
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
      end else begin
         start_seen <= start_tgl;
         stop_seen  <= stop_tgl;
         if (start_pend) begin
            state   <= LINK_ADDR;
            shift   <= {6'h00, sda_i};
            bit_cnt <= FIRST_BIT_DONE;
         end else if (stop_pend) begin
            state   <= LINK_IDLE;
            bit_cnt <= 4'h0;
         end else begin
            case (state)
               LINK_ADDR, LINK_CMD, LINK_WDATA: begin
                  if (bit_cnt == ACK_BIT) begin
                     bit_cnt <= 4'h0;
                     if (state == LINK_ADDR) begin
                        // silent on mismatch, else by direction
                        state <= !ack_en ? LINK_WAIT : (rw ? LINK_RDATA : LINK_CMD);
                     end else begin
                        state <= LINK_WDATA;
                     end
                  end else begin
                     shift   <= rx_byte[6:0];
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
               LINK_RDATA: begin
                  if (bit_cnt == ACK_BIT) begin
                     bit_cnt <= 4'h0;
                     if (!master_ack) begin
                        state <= LINK_WAIT;
                     end
                  end else begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
               default: begin
                  // Idle or waiting for STOP: bits are ignored
                  bit_cnt <= 4'h0;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Acknowledge decision and direction bit
   always_ff @(posedge serial_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_en <= 1'b0;
         rw     <= 1'b0;
      end else if (start_pend || stop_pend) begin
         ack_en <= 1'b0;
      end else if (bit_cnt == LAST_DATA_BIT) begin
         if (state == LINK_ADDR) begin
            ack_en <= addr_hit;
            rw     <= sda_i;
         end else begin
            ack_en <= (state == LINK_CMD) || (state == LINK_WDATA);
         end
      end else if (bit_cnt == ACK_BIT) begin
         ack_en <= 1'b0;
      end
   end

   // ==========================================================
   // Register pointer and requests to the register side
   // Words stay still until the next byte, so the far side may read them
   // once it has seen the toggle.
   always_ff @(posedge serial_clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr     <= REG_INPUT0;
         wr_word <= '0;
         wr_tgl  <= 1'b0;
         rd_ptr  <= REG_INPUT0;
         rd_tgl  <= 1'b0;
      end else if (!start_pend && !stop_pend) begin
         if (state == LINK_CMD && bit_cnt == LAST_DATA_BIT) begin
            ptr <= rx_byte[2:0];
         end else if (state == LINK_WDATA && bit_cnt == LAST_DATA_BIT) begin
            wr_word <= '{idx: ptr, data: rx_byte};
            wr_tgl  <= ~wr_tgl;
            ptr     <= {ptr[2:1], ~ptr[0]};
         end else if (bit_cnt == ACK_BIT &&
                      ((state == LINK_ADDR && ack_en && rw) ||
                       (state == LINK_RDATA && master_ack))) begin
            rd_ptr <= ptr;
            rd_tgl <= ~rd_tgl;
            // next read from the other register
            ptr    <= {ptr[2:1], ~ptr[0]};
         end
      end
   end

   // ==========================================================
   // Data line drive, falling clock edge
   // only a pull-low enable; the driven level is always low
   always_ff @(negedge serial_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe <= 1'b0;
         sda_o  <= 1'b0;
         tx     <= 8'h00;
      end else if (start_pend || stop_pend) begin
         sda_oe <= 1'b0;
      end else if (bit_cnt == ACK_BIT && ack_en) begin
         // hold low through the ninth clock
         sda_oe <= 1'b1;
      end else if (state == LINK_RDATA && bit_cnt == 4'h0) begin
         // Register side answered well within the clock high time
         tx     <= {rd_data[6:0], 1'b0};
         sda_oe <= ~rd_data[7];
      end else if (state == LINK_RDATA && bit_cnt < ACK_BIT) begin
         tx     <= {tx[6:0], 1'b0};
         sda_oe <= ~tx[7];
      end else begin
         sda_oe <= 1'b0;
      end
   end

   // ==========================================================
   // Crossing into the register clock
   assign sync_in = {port_high_pins_i, port_low_pins_i,
                     addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
                     wr_tgl, rd_tgl};

   level_sync #(
      .WIDTH (21)
   ) u_sync (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .d     (sync_in),
      .q     (sync_out)
   );

   assign high_sync   = sync_out[20:13];
   assign low_sync    = sync_out[12:5];
   assign strap       = sync_out[4:2];
   assign wr_tgl_sync = sync_out[1];
   assign rd_tgl_sync = sync_out[0];
   assign wr_evt      = wr_tgl_sync != wr_seen;
   assign rd_evt      = rd_tgl_sync != rd_seen;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_seen <= 1'b0;
         rd_seen <= 1'b0;
      end else begin
         wr_seen <= wr_tgl_sync;
         rd_seen <= rd_tgl_sync;
      end
   end

   // ==========================================================
   // Port banks
   assign bank_pins[0] = low_sync;
   assign bank_pins[1] = high_sync;

   for (genvar k = 0; k < 2; k++) begin : g_bank
      port_bank u_bank (
         .clk       (ref_clk),
         .rst_n     (rst_n),
         .pins      (bank_pins[k]),
         // Input register writes are ignored
         .wr_en     (wr_evt && reg_port(wr_word.idx) == 1'(k) &&
                     reg_pair(wr_word.idx) != PAIR_INPUT),
         .wr_pair   (reg_pair(wr_word.idx)),
         .wr_data   (wr_word.data),
         // read clears only its own port
         .rd_clr    (rd_evt && reg_pair(rd_ptr) == PAIR_INPUT &&
                     reg_port(rd_ptr) == 1'(k)),
         .in_value  (bank_in[k]),
         .out_value (bank_out[k]),
         .pol_value (bank_pol[k]),
         .cfg_value (bank_cfg[k]),
         .change    (bank_change[k]),
         .pin_out   (bank_pout[k]),
         .pin_oe    (bank_poe[k])
      );
   end

   assign port_low_pins_o   = bank_pout[0];
   assign port_low_pins_oe  = bank_poe[0];
   assign port_high_pins_o  = bank_pout[1];
   assign port_high_pins_oe = bank_poe[1];

   // ==========================================================
   // Read data capture
   // Output registers read back the flop, not the pin
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
      end else if (rd_evt) begin
         case (reg_pair(rd_ptr))
            PAIR_INPUT:    rd_data <= bank_in[reg_port(rd_ptr)];
            PAIR_OUTPUT:   rd_data <= bank_out[reg_port(rd_ptr)];
            PAIR_POLARITY: rd_data <= bank_pol[reg_port(rd_ptr)];
            PAIR_CONFIG:   rd_data <= bank_cfg[reg_port(rd_ptr)];
            default:       rd_data <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Interrupt pin, open drain
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_n_oe <= 1'b0;
         int_n_o  <= 1'b0;
      end else begin
         int_n_oe <= |bank_change;
         int_n_o  <= 1'b0;
      end
   end

endmodule // i2c_port_expander_slave

// >>> hdl/level_sync.sv
/*
   Two-flop synchroniser for a bundle of independent levels.
   Assumes each bit is a level or a toggle that holds for several clocks.
*/
`timescale 1ns/1ps
module level_sync
   import pexp_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage1;

   // ==========================================================
   // Stage one is read only by stage two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         q      <= '0;
      end else begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule // level_sync

// >>> hdl/port_bank.sv
/*
   One 8-bit port: output, polarity and direction registers, the read
   reference for change detection and the pin drivers.
   Assumes pins arrive already synchronised to clk.
*/
`timescale 1ns/1ps
module port_bank
   import pexp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] pins,
   input  wire logic       wr_en,
   input  wire logic [1:0] wr_pair,
   input  wire logic [7:0] wr_data,
   input  wire logic       rd_clr,
   output logic      [7:0] in_value,
   output logic      [7:0] out_value,
   output logic      [7:0] pol_value,
   output logic      [7:0] cfg_value,
   output logic            change,
   output logic      [7:0] pin_out,
   output logic      [7:0] pin_oe
);

   logic [7:0] ref_value;
   logic [2:0] warm;

   assign in_value = pins ^ pol_value;

   // ==========================================================
   // Software registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_value <= OUTPUT_RESET;
         pol_value <= POLARITY_RESET;
         cfg_value <= CONFIG_RESET;
      end else if (wr_en) begin
         case (wr_pair)
            PAIR_OUTPUT:   out_value <= wr_data;
            PAIR_POLARITY: pol_value <= wr_data;
            PAIR_CONFIG:   cfg_value <= wr_data;
            default:       out_value <= out_value;
         endcase
      end
   end

   // ==========================================================
   // Change reference
   // Reloaded until the pin synchroniser has filled after reset, so the
   // zeros it starts from are not taken for a change at power-up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         warm <= 3'h0;
      end else begin
         warm <= {warm[1:0], 1'b1};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_value <= 8'h00;
      end else if (!warm[2] || rd_clr) begin
         ref_value <= in_value;
      end
   end

   // ==========================================================
   // Change flag and pin drive
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         change <= 1'b0;
      end else begin
         change <= warm[2] && !rd_clr && |((in_value ^ ref_value) & cfg_value);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= OUTPUT_RESET;
         pin_oe  <= 8'h00;
      end else begin
         pin_out <= out_value;
         pin_oe  <= ~cfg_value;
      end
   end

endmodule // port_bank

// >>> pkg/pexp_pkg.sv
/*
   Shared constants and types of the two-port I/O expander slave.
   Assumes it is compiled before every design file that imports it.
*/
package pexp_pkg;

   // ==========================================================
   // Slave address
   localparam logic [3:0] ADDR_PREFIX     = 4'h4;

   // ==========================================================
   // Register pointer coding (pair in bits 2:1, port in bit 0)
   localparam logic [2:0] REG_INPUT0      = 3'h0;
   localparam logic [2:0] REG_INPUT1      = 3'h1;
   localparam logic [2:0] REG_OUTPUT0     = 3'h2;
   localparam logic [2:0] REG_OUTPUT1     = 3'h3;
   localparam logic [2:0] REG_POLARITY0   = 3'h4;
   localparam logic [2:0] REG_POLARITY1   = 3'h5;
   localparam logic [2:0] REG_CONFIG0     = 3'h6;
   localparam logic [2:0] REG_CONFIG1     = 3'h7;
   localparam logic [1:0] PAIR_INPUT      = 2'h0;
   localparam logic [1:0] PAIR_OUTPUT     = 2'h1;
   localparam logic [1:0] PAIR_POLARITY   = 2'h2;
   localparam logic [1:0] PAIR_CONFIG     = 2'h3;

   // ==========================================================
   // Reset values
   localparam logic [7:0] OUTPUT_RESET    = 8'hFF;
   localparam logic [7:0] POLARITY_RESET  = 8'h00;
   localparam logic [7:0] CONFIG_RESET    = 8'hFF;

   // ==========================================================
   // Bit counting within a byte frame
   localparam logic [3:0] FIRST_BIT_DONE  = 4'h1;
   localparam logic [3:0] LAST_DATA_BIT   = 4'h7;
   localparam logic [3:0] ACK_BIT         = 4'h8;

   // ==========================================================
   // Types
   typedef enum logic [5:0] {
      LINK_IDLE  = 6'b00_0001,
      LINK_ADDR  = 6'b00_0010,
      LINK_CMD   = 6'b00_0100,
      LINK_WDATA = 6'b00_1000,
      LINK_RDATA = 6'b01_0000,
      LINK_WAIT  = 6'b10_0000
   } link_state_t;

   typedef struct packed {
      logic [2:0] idx;
      logic [7:0] data;
   } reg_write_t;

   function automatic logic [1:0] reg_pair(input logic [2:0] idx);
      return idx[2:1];
   endfunction

   function automatic logic reg_port(input logic [2:0] idx);
      return idx[0];
   endfunction

endpackage

// >>> sim/i2c_bus_master_model.sv
/* Serial bus master: makes clock, START and STOP, pulls data low.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/1ps
module i2c_bus_master_model (
   output logic     scl,
   output logic     pull,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   // START from idle or released line
   task automatic start();
      pull = 1'b0;
      #70;
      scl = 1'b1;
      #80;
      pull = 1'b1;
      #80;
      scl = 1'b0;
      #10;
   endtask
   // data moves only in clock low
   task automatic bit_x(input logic b, input int hi, output logic s);
      pull = !b;
      #70;
      scl = 1'b1;
      #(hi);
      s = sda;
      scl = 1'b0;
      #10;
   endtask
   // Ninth clock held long: the slave needs a few core clocks to answer
   task automatic wr(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(d[i], 80, s);
      bit_x(1'b1, 640, s);
      ack = !s;
   endtask
   // master ack, or withheld on the last byte
   task automatic rd(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 0; i < 8; i++) begin
         bit_x(1'b1, 80, s);
         d = {d[6:0], s};
      end
      bit_x(!ack, 640, s);
   endtask
   task automatic stop();
      pull = 1'b1;
      #70;
      scl = 1'b1;
      #80;
      pull = 1'b0;
      #160;
   endtask
endmodule // i2c_bus_master_model

// >>> sim/i2c_port_expander_slave_checker.sv
/* Checker for the expander slave top, bound to it below.
   Assumes serial lines never change on a ref_clk edge. */
`timescale 1ns/1ps
module i2c_port_expander_slave_checker
   import pexp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic serial_clk,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic addr_strap_bit0,
   input wire logic addr_strap_bit1,
   input wire logic addr_strap_bit2
);
   // ==========================================================
   // Bus tracker, oversampled by ref_clk
   logic       sq, dq, seen, first, rd, mat, nak, rise, strt, ninth, mtch;
   logic [3:0] cnt;
   logic [7:0] sh;
   assign rise  = serial_clk & ~sq;
   assign strt  = serial_clk & sq & dq & ~sda_i;
   assign ninth = rise & (cnt == 4'h8);
   assign mtch  = sh[7:1] == {ADDR_PREFIX, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         {sq, dq, seen, first, rd, mat, nak} <= 7'h60;
         cnt <= 4'h0;
         sh  <= 8'h00;
      end else begin
         sq <= serial_clk;
         dq <= sda_i;
         if (strt) begin
            {seen, first, nak} <= 3'h6;
            cnt <= 4'h0;
         end else if (rise) begin
            cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
            if (cnt != 4'h8) sh <= {sh[6:0], sda_i};
            if (ninth) first <= 1'b0;
            if (ninth && first) {rd, mat} <= {sh[0], mtch};
            if (ninth && !first && rd && mat && sda_i) nak <= 1'b1;
         end
      end
   end
   // ==========================================================
   // Properties
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_sda_drain_only: assert property (sda_oe |-> !sda_o)
      else $error("data line driven high");
   a_quiet_before_start: assert property (!seen |-> !sda_oe)
      else $error("drive before start");
   a_addr_ack: assert property (ninth && first |-> sda_oe == mtch)
      else $error("address ack wrong");
   a_write_ack: assert property (ninth && !first && mat && !rd |-> sda_oe)
      else $error("write byte not acked");
   a_ack_held: assert property (ninth && sda_oe |-> ##1 sda_oe [*3])
      else $error("ack not held");
   a_read_release: assert property (ninth && !first && mat && rd |-> !sda_oe)
      else $error("line kept in ack slot");
   a_nak_silent: assert property (nak |-> !sda_oe)
      else $error("sending after nack");
   a_oe_steady_high: assert property (serial_clk && sq |-> $stable(sda_oe))
      else $error("data moved in clock high");
endmodule // i2c_port_expander_slave_checker

bind i2c_port_expander_slave i2c_port_expander_slave_checker u_checker (
   .ref_clk, .reset_n, .serial_clk, .sda_i, .sda_o, .sda_oe,
   .addr_strap_bit0, .addr_strap_bit1, .addr_strap_bit2);

// >>> sim/i2c_port_expander_slave_tb.sv
/* Bench for the expander slave: master model on the bus, pins fed
   back through their drivers. Assumes the checker binds itself. */
`timescale 1ns/1ps
module i2c_port_expander_slave_tb;
   localparam logic [7:0] AW = 8'h4A;
   localparam logic [7:0] AR = 8'h4B;
   logic        ref_clk, reset_n, scl, pull, sda, sda_o, sda_oe, int_n_o, int_n_oe;
   logic [7:0]  lo_o, lo_oe, hi_o, hi_oe, ext_lo, ext_hi, v0, v1;
   logic [3:0]  ak;
   logic [18:0] rows [8];
   logic [7:0]  bad [4];
   int          num_errors = 0;
   int          n_compared = 0;
   assign sda = !(pull | (sda_oe & !sda_o));
   i2c_bus_master_model m (.scl(scl), .pull(pull), .sda(sda));
   i2c_port_expander_slave dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .serial_clk(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_bit0(1'b1),
      .addr_strap_bit1(1'b0), .addr_strap_bit2(1'b1),
      .port_low_pins_i((lo_o & lo_oe) | (ext_lo & ~lo_oe)),
      .port_low_pins_o(lo_o), .port_low_pins_oe(lo_oe),
      .port_high_pins_i((hi_o & hi_oe) | (ext_hi & ~hi_oe)),
      .port_high_pins_o(hi_o), .port_high_pins_oe(hi_oe),
      .int_n_o(int_n_o), .int_n_oe(int_n_oe));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cint(input logic e);
      repeat (10) @(negedge ref_clk);
      chk("irq", {7'h00, e}, {7'h00, int_n_oe});
      chk("irq level", 8'h00, {7'h00, int_n_o});
   endtask
   task automatic wrreg(input logic [2:0] i, input logic [7:0] d);
      logic [2:0] a;
      m.start();
      m.wr(AW, a[0]);
      m.wr({5'h00, i}, a[1]);
      m.wr(d, a[2]);
      m.stop();
      chk("write acks", 8'h07, {5'h00, a});
   endtask
   task automatic rdreg(input logic [2:0] i, input logic two);
      logic [2:0] a;
      m.start();
      m.wr(AW, a[0]);
      m.wr({5'h00, i}, a[1]);
      m.start();
      m.wr(AR, a[2]);
      m.rd(two, v0);
      if (two) m.rd(1'b0, v1);
      m.stop();
      chk("read acks", 8'h07, {5'h00, a});
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      #1_000_000;
      num_errors++;
      tally_and_finish();
   end
   // ==========================================================
   // Main sequence
   initial begin
      rows = '{{3'h2, 8'h3C, 8'h3C}, {3'h3, 8'hC3, 8'hC3}, {3'h4, 8'h0F, 8'h0F},
               {3'h5, 8'h00, 8'h00}, {3'h6, 8'hF0, 8'hF0}, {3'h7, 8'hFF, 8'hFF},
               {3'h0, 8'h11, 8'hA3}, {3'h1, 8'h11, 8'h5A}};
      bad = '{8'h48, 8'h5A, 8'hCA, 8'h4E};
      reset_n = 1'b0;
      ext_lo = 8'hA5;
      ext_hi = 8'h5A;
      repeat (8) @(negedge ref_clk);
      chk("pins in reset", 8'hFF, lo_o & hi_o);
      chk("drive in reset", 8'h00, lo_oe | hi_oe | {6'h00, sda_oe, int_n_oe});
      reset_n = 1'b1;
      repeat (6) @(negedge ref_clk);
      cint(1'b0);
      for (int i = 2; i < 8; i++) begin
         rdreg(3'(i), 1'b0);
         chk("reset value", (i / 2 == 2) ? 8'h00 : 8'hFF, v0);
      end
      foreach (rows[k]) begin
         wrreg(rows[k][18:16], rows[k][15:8]);
         rdreg(rows[k][18:16], 1'b0);
         chk("register", rows[k][7:0], v0);
      end
      chk("low out", 8'h3C, lo_o);
      chk("low drive", 8'h0F, lo_oe);
      chk("high drive", 8'h00, hi_oe);
      cint(1'b0);
      ext_hi = 8'h5B;
      cint(1'b1);
      ext_hi = 8'h5A;
      cint(1'b0);
      ext_hi = 8'h5B;
      rdreg(3'h0, 1'b0);
      cint(1'b1);
      rdreg(3'h1, 1'b0);
      chk("input high", 8'h5B, v0);
      cint(1'b0);
      wrreg(3'h6, 8'hFF);
      cint(1'b1);
      rdreg(3'h0, 1'b0);
      chk("input low", 8'hAA, v0);
      m.start();
      m.wr(AW, ak[0]);
      m.wr(8'h03, ak[1]);
      m.wr(8'h81, ak[2]);
      m.wr(8'h7E, ak[3]);
      m.stop();
      chk("pair acks", 8'h0F, {4'h0, ak});
      chk("pair first", 8'h81, hi_o);
      chk("pair flip", 8'h7E, lo_o);
      rdreg(3'h2, 1'b1);
      chk("read first", 8'h7E, v0);
      chk("read flip", 8'h81, v1);
      foreach (bad[k]) begin
         m.start();
         m.wr(bad[k], ak[0]);
         m.stop();
         chk("foreign address", 8'h00, {7'h00, ak[0]});
      end
      // ==========================================================
      // Reset in mid-run, with outputs away from reset values and flags already clear
      reset_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("pins after reset", 8'hFF, lo_o & hi_o);
      chk("drive after reset", 8'h00, lo_oe | hi_oe | {6'h00, sda_oe, int_n_oe});
      reset_n = 1'b1;
      repeat (6) @(negedge ref_clk);
      cint(1'b0);
      rdreg(3'h3, 1'b0);
      chk("out after reset", 8'hFF, v0);
      tally_and_finish();
   end
endmodule // i2c_port_expander_slave_tb
